// ---- rtl/lcdc_top.sv ----
// Panel drive, contrast and segment memory with an AXI4-Lite register slave
// Notes on behaviour
// [RULE1] Drive-time code picks 300,70,150,450,575,850,1150 us or half panel period.
// [RULE2] Drive time is never longer than half a panel clock period.
// [RULE3] Static duty or blanking forces drive time to half a panel period.
// [RULE4] Drive-time writes act immediately; small glitches are accepted.
// [RULE5] Software should blank and wait for frame start before changing drive time.
// [RULE6] Max-drive bit keeps the drivers on continuously.
// [RULE7] Contrast code selects max voltage from 2.60 to 3.35 in 0.05 steps.
// [RULE8] New contrast code takes effect only at the next frame start.
// [RULE9] A memory bit of one lights its segment; zero leaves it dark.
// [RULE10] Memory bits without a segment still read and write as storage.
// [RULE11] Five bytes per common line; byte k bit b is segment 8k+b.
// [RULE12] Drive timing follows the prescaled panel clock from prescaler and divider.
// [RULE13] Reset clears control register and all twenty memory bytes.
`timescale 1ns/1ns
`default_nettype none
module lcdc_top #(
    parameter int unsigned DRIVE_CYC0 = lcdc_pkg::LCDC_T0_CYC,
    parameter int unsigned DRIVE_CYC1 = lcdc_pkg::LCDC_T1_CYC,
    parameter int unsigned DRIVE_CYC2 = lcdc_pkg::LCDC_T2_CYC,
    parameter int unsigned DRIVE_CYC3 = lcdc_pkg::LCDC_T3_CYC,
    parameter int unsigned DRIVE_CYC4 = lcdc_pkg::LCDC_T4_CYC,
    parameter int unsigned DRIVE_CYC5 = lcdc_pkg::LCDC_T5_CYC,
    parameter int unsigned DRIVE_CYC6 = lcdc_pkg::LCDC_T6_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Rest of the panel unit
    input wire logic prescaled_panel_clock,
    input wire logic frame_start,
    input wire logic display_blank,
    input wire logic static_duty,
    // Panel drive outputs
    output logic drivers_on,
    output logic [3:0] contrast_level,
    output logic [39:0] seg_com0,
    output logic [39:0] seg_com1,
    output logic [39:0] seg_com2,
    output logic [39:0] seg_com3
);
    import lcdc_pkg::*;

    typedef struct packed {
        logic aw_have;
        logic [4:0] aw_slot;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [LCDC_MEM_BYTES-1:0][7:0] mem;
    } lcdc_regs_type;

    lcdc_regs_type q, d;
    logic [4:0] rd_slot;
    logic commit;
    logic [LCDC_CNT_W-1:0] half_cycles;

    // Map a byte address to a register slot
    function automatic logic [4:0] reg_slot(input logic [11:0] a);
        logic [9:0] idx;
        logic [9:0] rel;
        idx = a[11:2];
        rel = idx - LCDC_IDX_MEM0;
        if (idx == LCDC_IDX_CTRL) begin
            reg_slot = LCDC_SLOT_CTRL;
        end else if (idx == LCDC_IDX_STATUS) begin
            reg_slot = LCDC_SLOT_STATUS;
        end else if (idx >= LCDC_IDX_MEM0 && rel < 10'(LCDC_MEM_BYTES)) begin
            reg_slot = rel[4:0];
        end else begin
            reg_slot = LCDC_SLOT_NONE;
        end
    endfunction : reg_slot

    function automatic logic is_mem(input logic [4:0] s);
        is_mem = s < 5'(LCDC_MEM_BYTES);
    endfunction : is_mem

    assign rd_slot = reg_slot(araddr);
    assign commit = q.aw_have && q.w_have && !q.bvalid;

    always_comb begin
        d = q;
        // Address and data are taken independently, in either order
        if (awvalid && !q.aw_have) begin
            d.aw_have = 1'b1;
            d.aw_slot = reg_slot(awaddr);
        end
        if (wvalid && !q.w_have) begin
            d.w_have = 1'b1;
            d.w_data = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end

        // Response leaves once the master takes it
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end

        // Commit once both halves are held
        if (commit) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = LCDC_RESP_OKAY;
            if (q.aw_slot == LCDC_SLOT_CTRL) begin
                if (q.w_lane0) begin
                    d.ctrl = q.w_data;
                end
            end else if (is_mem(q.aw_slot)) begin
                // [RULE10] Every memory bit is plain storage
                if (q.w_lane0) begin
                    d.mem[q.aw_slot] = q.w_data;
                end
            end else if (q.aw_slot != LCDC_SLOT_STATUS) begin
                d.bresp = LCDC_RESP_SLVERR;
            end
        end

        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        // Read data answers one cycle after the address is taken
        if (arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = LCDC_RESP_OKAY;
            d.rdata = 32'h0000_0000;
            if (rd_slot == LCDC_SLOT_CTRL) begin
                d.rdata = {24'h00_0000, q.ctrl};
            end else if (rd_slot == LCDC_SLOT_STATUS) begin
                // Measured half period, live drive state and applied contrast
                d.rdata = {6'h00, half_cycles, 3'h0, drivers_on, contrast_level};
            end else if (is_mem(rd_slot)) begin
                // [RULE10] Unattached bits read back as written
                d.rdata = {24'h00_0000, q.mem[rd_slot]};
            end else begin
                d.rresp = LCDC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // [RULE13] Everything cleared, all segments dark
            q <= '0;
            q.ctrl <= LCDC_CTRL_RST;
            q.mem <= {LCDC_MEM_BYTES{LCDC_MEM_RST}};
        end else begin
            q <= d;
        end
    end

    assign awready = !q.aw_have;
    assign wready = !q.w_have;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;

    // [RULE9] Memory bits drive the segment lines directly
    // [RULE11] Five bytes per common, byte k holds segments 8k to 8k+7
    assign seg_com0 = q.mem[4:0];
    assign seg_com1 = q.mem[9:5];
    assign seg_com2 = q.mem[14:10];
    assign seg_com3 = q.mem[19:15];

    // Blanking shares the half-period drive with static duty; with static duty low, toggling blank switches drive time between the selected code and half period
    lcdc_drive #(
        .C0(DRIVE_CYC0),
        .C1(DRIVE_CYC1),
        .C2(DRIVE_CYC2),
        .C3(DRIVE_CYC3),
        .C4(DRIVE_CYC4),
        .C5(DRIVE_CYC5),
        .C6(DRIVE_CYC6)
    ) u_drive (
        .aclk(aclk),
        .aresetn(aresetn),
        .panel_clk(prescaled_panel_clock),
        .drive_time_select(q.ctrl[LCDC_DT_LSB +: 3]),
        .max_drive_always_on(q.ctrl[LCDC_MAXDRV_BIT]),
        .full_half(static_duty | display_blank),
        .drivers_on(drivers_on),
        .half_cycles(half_cycles)
    );

    lcdc_contrast u_contrast (
        .aclk(aclk),
        .aresetn(aresetn),
        .code_written(q.ctrl[LCDC_CC_LSB +: 4]),
        .frame_start(frame_start),
        .contrast_level(contrast_level)
    );

    // Bus, mapping and reset checks
    a_write_answer: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        $rose(q.bvalid) |-> $past(q.aw_have && q.w_have)
    ) else $error("write answered without both halves");

    a_bresp_hold: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (q.bvalid && !bready) |=> q.bvalid && $stable(q.bresp)
    ) else $error("write response dropped");

    a_read_answer: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready) |=> rvalid
    ) else $error("read not answered next cycle");

    a_rdata_hold: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (rvalid && !rready) |=> rvalid && $stable(rdata)
    ) else $error("read data changed while held");

    a_ctrl_write: assert property ( // [RULE4]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == LCDC_SLOT_CTRL) |=> q.ctrl == $past(q.w_data)
    ) else $error("control write lost");

    a_max_drive_wr: assert property ( // [RULE6]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == LCDC_SLOT_CTRL && q.w_data[LCDC_MAXDRV_BIT])
        |=> drivers_on
    ) else $error("max drive write did not turn drivers on");

    a_ctrl_read: assert property ( // [RULE6]
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && rd_slot == LCDC_SLOT_CTRL)
        |=> rdata == {24'h00_0000, $past(q.ctrl)}
    ) else $error("control read back wrong");

    a_status_ro: assert property ( // [RULE6]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.aw_slot == LCDC_SLOT_STATUS)
        |=> $stable(q.ctrl) && bresp == LCDC_RESP_OKAY
    ) else $error("status write disturbed control");

    a_contrast_wait: assert property ( // [RULE8]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.aw_slot == LCDC_SLOT_CTRL && !frame_start)
        |=> $stable(contrast_level)
    ) else $error("contrast moved without frame start");

    a_mem_write: assert property ( // [RULE11]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == 5'h03) |=> seg_com0[31:24] == $past(q.w_data)
    ) else $error("memory byte not on its segments");

    a_seg_com1: assert property ( // [RULE9]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == 5'h05) |=> seg_com1[7:0] == $past(q.w_data)
    ) else $error("common one segments wrong");

    a_seg_com2: assert property ( // [RULE11]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == 5'h0c) |=> seg_com2[23:16] == $past(q.w_data)
    ) else $error("common two segments wrong");

    a_seg_com3: assert property ( // [RULE11]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.w_lane0 && q.aw_slot == 5'h13) |=> seg_com3[39:32] == $past(q.w_data)
    ) else $error("common three segments wrong");

    a_strobe_keep: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (commit && !q.w_lane0)
        |=> $stable(q.mem) && $stable(q.ctrl)
    ) else $error("write without strobe changed storage");

    a_mem_read: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && is_mem(rd_slot))
        |=> rdata == {24'h00_0000, $past(q.mem[rd_slot])}
    ) else $error("memory read back wrong");

    a_mem_okay: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (commit && is_mem(q.aw_slot))
        |=> bvalid && bresp == LCDC_RESP_OKAY
    ) else $error("memory write not accepted");

    a_write_err: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (commit && q.aw_slot == LCDC_SLOT_NONE)
        |=> bvalid && bresp == LCDC_RESP_SLVERR
    ) else $error("unmapped write not refused");

    a_unmapped_err: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && rd_slot == LCDC_SLOT_NONE) |=> rresp == LCDC_RESP_SLVERR
    ) else $error("unmapped read not refused");

    a_reset_dark: assert property ( // [RULE13]
        @(posedge aclk)
        !aresetn |=> seg_com0 == 40'h00_0000_0000 && seg_com3 == 40'h00_0000_0000 && !drivers_on
    ) else $error("segments lit after reset");

    a_reset_regs: assert property ( // [RULE13]
        @(posedge aclk)
        !aresetn |=> q.ctrl == LCDC_CTRL_RST && contrast_level == LCDC_CC_RST
            && seg_com1 == '0 && seg_com2 == '0
    ) else $error("registers not cleared by reset");
endmodule : lcdc_top
`default_nettype wire

// ---- rtl/lcdc_pkg.sv ----
// Shared constants for the panel drive, contrast and segment memory block
package lcdc_pkg;
    // System clock rate
    localparam int unsigned LCDC_CLK_MHZ = 100;
    // Nominal drive times per drive_time_select code, in microseconds
    localparam int unsigned LCDC_T0_US = 300;
    localparam int unsigned LCDC_T1_US = 70;
    localparam int unsigned LCDC_T2_US = 150;
    localparam int unsigned LCDC_T3_US = 450;
    localparam int unsigned LCDC_T4_US = 575;
    localparam int unsigned LCDC_T5_US = 850;
    localparam int unsigned LCDC_T6_US = 1150;
    // Drive times in clock cycles
    localparam int unsigned LCDC_T0_CYC = LCDC_T0_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T1_CYC = LCDC_T1_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T2_CYC = LCDC_T2_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T3_CYC = LCDC_T3_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T4_CYC = LCDC_T4_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T5_CYC = LCDC_T5_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_T6_CYC = LCDC_T6_US * LCDC_CLK_MHZ;
    localparam int unsigned LCDC_CNT_W = 18;
    localparam logic [2:0] LCDC_DT_HALF = 3'h7;
    // Register indices; byte address is four times the index
    localparam logic [9:0] LCDC_IDX_CTRL = 10'h0e7;
    localparam logic [9:0] LCDC_IDX_STATUS = 10'h0e8;
    localparam logic [9:0] LCDC_IDX_MEM0 = 10'h0100;
    localparam int unsigned LCDC_MEM_BYTES = 20;
    // Internal decode slots
    localparam logic [4:0] LCDC_SLOT_CTRL = 5'h14;
    localparam logic [4:0] LCDC_SLOT_STATUS = 5'h15;
    localparam logic [4:0] LCDC_SLOT_NONE = 5'h1f;
    // Fields of contrast_drive_ctrl
    localparam int unsigned LCDC_DT_LSB = 5;
    localparam int unsigned LCDC_MAXDRV_BIT = 4;
    localparam int unsigned LCDC_CC_LSB = 0;
    // Reset values
    localparam logic [7:0] LCDC_CTRL_RST = 8'h00;
    localparam logic [7:0] LCDC_MEM_RST = 8'h00;
    localparam logic [3:0] LCDC_CC_RST = 4'h0;
    // Bus responses
    localparam logic [1:0] LCDC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LCDC_RESP_SLVERR = 2'h2;
endpackage : lcdc_pkg

// ---- rtl/lcdc_drive.sv ----
// Driver on-time generator timed by the prescaled panel clock
`timescale 1ns/1ns
`default_nettype none
module lcdc_drive #(
    parameter int unsigned C0 = lcdc_pkg::LCDC_T0_CYC,
    parameter int unsigned C1 = lcdc_pkg::LCDC_T1_CYC,
    parameter int unsigned C2 = lcdc_pkg::LCDC_T2_CYC,
    parameter int unsigned C3 = lcdc_pkg::LCDC_T3_CYC,
    parameter int unsigned C4 = lcdc_pkg::LCDC_T4_CYC,
    parameter int unsigned C5 = lcdc_pkg::LCDC_T5_CYC,
    parameter int unsigned C6 = lcdc_pkg::LCDC_T6_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Timing inputs
    input wire logic panel_clk,
    input wire logic [2:0] drive_time_select,
    input wire logic max_drive_always_on,
    input wire logic full_half,
    // Outputs
    output logic drivers_on,
    output logic [lcdc_pkg::LCDC_CNT_W-1:0] half_cycles
);
    import lcdc_pkg::*;
    typedef struct packed {
        logic clk_prev;
        logic active;
        logic [LCDC_CNT_W-1:0] since;
        logic [LCDC_CNT_W-1:0] half;
        logic [LCDC_CNT_W-1:0] on_cnt;
    } lcdc_drv_type;
    lcdc_drv_type q, d;
    logic edge_seen;
    logic [LCDC_CNT_W-1:0] limit;

    function automatic logic [LCDC_CNT_W-1:0] sel_cycles(input logic [2:0] s);
        case (s)
            3'h0: sel_cycles = LCDC_CNT_W'(C0);
            3'h1: sel_cycles = LCDC_CNT_W'(C1);
            3'h2: sel_cycles = LCDC_CNT_W'(C2);
            3'h3: sel_cycles = LCDC_CNT_W'(C3);
            3'h4: sel_cycles = LCDC_CNT_W'(C4);
            3'h5: sel_cycles = LCDC_CNT_W'(C5);
            3'h6: sel_cycles = LCDC_CNT_W'(C6);
            default: sel_cycles = '1;
        endcase
    endfunction : sel_cycles

    // [RULE12] Both panel clock edges
    assign edge_seen = panel_clk != q.clk_prev;

    always_comb begin
        d = q;
        limit = q.half;
        // [RULE1] Selected drive time
        if (drive_time_select != LCDC_DT_HALF && !full_half) begin
            // [RULE2] Clip to half period
            if (sel_cycles(drive_time_select) < q.half) begin
                limit = sel_cycles(drive_time_select);
            end
        end
        // [RULE3] Static or blank uses half period, set above
        d.clk_prev = panel_clk;
        if (edge_seen) begin
            d.half = (q.since == '1) ? q.since : q.since + 1'b1;
            d.since = '0;
            d.on_cnt = '0;
            d.active = 1'b1;
        end else begin
            if (q.since != '1) begin
                d.since = q.since + 1'b1;
            end
            // [RULE4] Limit read live, so a new code acts at once
            if (q.active) begin
                d.on_cnt = q.on_cnt + 1'b1;
                if (q.on_cnt + 1'b1 >= limit) begin
                    d.active = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // [RULE6] Always on overrides timing
    assign drivers_on = max_drive_always_on | q.active;
    assign half_cycles = q.half;

    a_max_drive_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
        max_drive_always_on |-> drivers_on) else $error("max drive not on");
    a_drive_clip_half: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
        (q.active && q.half != '0) |-> q.on_cnt < q.half) else $error("drive exceeds half period");
    a_full_half_span: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
        (edge_seen && full_half && q.half > 18'h0_0003 && $stable(full_half)) |=> q.active [*2])
        else $error("half period drive ended early");
endmodule : lcdc_drive
`default_nettype wire

// ---- rtl/lcdc_contrast.sv ----
// Contrast code holder applied at frame start
`timescale 1ns/1ns
`default_nettype none
module lcdc_contrast (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Code and frame event
    input wire logic [3:0] code_written,
    input wire logic frame_start,
    // Applied code
    output logic [3:0] contrast_level
);
    import lcdc_pkg::*;
    typedef struct packed {
        logic [3:0] applied;
    } lcdc_cc_type;
    lcdc_cc_type q, d;

    always_comb begin
        d = q;
        // [RULE8] Apply only at frame start
        if (frame_start) begin
            d.applied = code_written;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.applied <= LCDC_CC_RST;
        end else begin
            q <= d;
        end
    end

    // [RULE7] Code 0 is lowest level, 0.05 per step
    assign contrast_level = q.applied;

    a_frame_apply: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
        frame_start |=> contrast_level == $past(code_written)) else $error("contrast not applied");
    a_contrast_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
        !frame_start |=> $stable(contrast_level)) else $error("contrast changed mid frame");
endmodule : lcdc_contrast
`default_nettype wire

// ---- test/lcdc_glass_model.sv ----
// Panel side model: prescaled panel clock source and driver on-time meter
`timescale 1ns/1ns
`default_nettype none
module lcdc_glass_model #(
    parameter int unsigned HALF = 100
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Panel side
    input wire logic drivers_on,
    output logic panel_clk,
    output logic [31:0] last_on
);
    logic [31:0] div_cnt;
    logic [31:0] on_cnt;
    logic prev_q;
    // panel clock source
    // Runs free, the way a prescaler tap followed by the divider does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 32'h0000_0000;
            panel_clk <= 1'b0;
        end else if (div_cnt == HALF - 1) begin
            div_cnt <= 32'h0000_0000;
            panel_clk <= !panel_clk;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
        end
    end
    // Counts on-cycles between two panel edges, so alignment offset does not matter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            on_cnt <= 32'h0000_0000;
            last_on <= 32'h0000_0000;
        end else begin
            prev_q <= panel_clk;
            if (panel_clk != prev_q) begin
                last_on <= on_cnt;
                on_cnt <= 32'(drivers_on);
            end else begin
                on_cnt <= on_cnt + 32'(drivers_on);
            end
        end
    end
endmodule : lcdc_glass_model
`default_nettype wire

// ---- test/tb.sv ----
// Register-level testbench for the panel drive, contrast and segment memory block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb;
    import lcdc_pkg::*;
    localparam int unsigned HALF = 100;
    localparam logic [11:0] A_CTRL = {LCDC_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {LCDC_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_MEM = {LCDC_IDX_MEM0, 2'b00};
    localparam int unsigned CYC [7] = '{30, 7, 15, 45, 57, 85, 115};
    int fail_count = 0;
    int check_count = 0;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] awaddr = 0;
    logic awvalid = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic wvalid = 0;
    logic bready = 0;
    logic [11:0] araddr = 0;
    logic arvalid = 0;
    logic rready = 0;
    logic [2:0] awprot = 3'h2;
    logic [2:0] arprot = 3'h2;
    logic frame_start = 0;
    logic display_blank = 0;
    logic static_duty = 0;
    logic awready, wready, bvalid, arready, rvalid, drivers_on, panel_clk;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd, last_on;
    logic [3:0] contrast_level;
    logic [39:0] seg_com0, seg_com1, seg_com2, seg_com3;
    logic [7:0] pat;

    initial begin
        forever #5 aclk = !aclk;
    end

    lcdc_top #(.DRIVE_CYC0(CYC[0]), .DRIVE_CYC1(CYC[1]), .DRIVE_CYC2(CYC[2]), .DRIVE_CYC3(CYC[3]),
        .DRIVE_CYC4(CYC[4]), .DRIVE_CYC5(CYC[5]), .DRIVE_CYC6(CYC[6])) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .prescaled_panel_clock(panel_clk), .frame_start(frame_start),
        .display_blank(display_blank), .static_duty(static_duty), .drivers_on(drivers_on),
        .contrast_level(contrast_level), .seg_com0(seg_com0), .seg_com1(seg_com1),
        .seg_com2(seg_com2), .seg_com3(seg_com3));

    lcdc_glass_model #(.HALF(HALF)) glass (.aclk(aclk), .aresetn(aresetn), .drivers_on(drivers_on),
        .panel_clk(panel_clk), .last_on(last_on));

    task automatic test_done();
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic hang();
        fail_count++;
        $display("Error bus wait expected answer seen none");
        test_done();
    endtask : hang

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (++n > 100) hang();
        end while (!(bvalid === 1'b1));
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdt(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (++n > 100) hang();
        end while (!(rvalid === 1'b1));
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdt

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    function automatic logic [7:0] seg_byte(int n);
        logic [39:0] s;
        s = n < 5 ? seg_com0 : n < 10 ? seg_com1 : n < 15 ? seg_com2 : seg_com3;
        return s[8 * (n % 5) +: 8];
    endfunction : seg_byte

    task automatic frame();
        @(posedge aclk);
        frame_start <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        @(posedge aclk);
    endtask : frame

    task automatic drv(input logic [2:0] code, input logic blank, input logic stat, input logic [31:0] exp);
        @(posedge aclk);
        display_blank <= blank;
        static_duty <= stat;
        wr(A_CTRL, {code, 5'h00}, 4'h1);
        repeat (4 * HALF) @(posedge aclk);
        `CHK("on time", exp, last_on)
    endtask : drv

    initial begin
        do_reset();
        rdt(A_CTRL);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        for (int n = 0; n < 20; n++) begin
            rdt(A_MEM + 12'(4 * n));
            `CHK("mem reset", 32'h0000_0000, rd)
        end
        for (int n = 0; n < 20; n++) begin
            wr(A_MEM + 12'(4 * n), 8'(n * 29 + 129), 4'h1);
            `CHK("mem write", LCDC_RESP_OKAY, resp)
        end
        for (int n = 0; n < 20; n++) begin
            pat = 8'(n * 29 + 129);
            rdt(A_MEM + 12'(4 * n));
            `CHK("mem read", {24'h00_0000, pat}, rd)
            `CHK("segments", pat, seg_byte(n))
        end
        wr(A_MEM + 12'h008, 8'h00, 4'h1);
        `CHK("segment off", 8'h00, seg_byte(2))
        wr(A_MEM + 12'h008, 8'hff, 4'h0);
        `CHK("strobe off", 8'h00, seg_byte(2))
        rdt(12'h7fc);
        `CHK("unmapped read", {LCDC_RESP_SLVERR, 32'h0000_0000}, {resp, rd})
        wr(12'h7fc, 8'h55, 4'h1);
        `CHK("unmapped write", LCDC_RESP_SLVERR, resp)
        do_reset();
        `CHK("segments after reset", 160'h0, {seg_com3, seg_com2, seg_com1, seg_com0})
        for (int c = 0; c < 6; c++) begin
            drv(3'(c), 1'b0, 1'b0, CYC[c] < HALF ? CYC[c] : HALF);
        end
        drv(3'h6, 1'b0, 1'b0, CYC[6] < HALF ? CYC[6] : HALF);
        drv(LCDC_DT_HALF, 1'b0, 1'b0, HALF);
        drv(3'h1, 1'b0, 1'b1, HALF);
        // blank and wait for a frame start before a drive-time change
        @(posedge aclk);
        display_blank <= 1'b1;
        frame();
        drv(3'h2, 1'b1, 1'b0, HALF);
        drv(3'h2, 1'b0, 1'b0, 15);
        wr(A_CTRL, 8'h30, 4'h1);
        repeat (4 * HALF) @(posedge aclk);
        `CHK("max drive", 32'(HALF), last_on)
        rdt(A_STAT);
        `CHK("status", {6'h00, 18'(HALF), 8'h10}, rd)
        wr(A_STAT, 8'hff, 4'h1);
        `CHK("status write", LCDC_RESP_OKAY, resp)
        rdt(A_CTRL);
        `CHK("ctrl kept", 32'h0000_0030, rd)
        for (int c = 1; c < 17; c++) begin
            wr(A_CTRL, 8'(c % 16), 4'h1);
            `CHK("contrast held", 4'(c - 1), contrast_level)
            frame();
            `CHK("contrast applied", 4'(c % 16), contrast_level)
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
